/* File: switch_spi_consts.svh */
// Purpose: constants for the six channel switch serial control block
// Assumes: included by bare name after the package
// Notes: command codes are control byte bits 7..2, low two bits ignored
`ifndef SWITCH_SPI_CONSTS_SVH
`define SWITCH_SPI_CONSTS_SVH

// frame shape
`define FRAME_BITS 5'h10
`define CNT_MAX 5'h1F
`define PREFIX_OK 2'h2
`define CMD_LAST_CNT 5'h07
`define DATA_LAST_CNT 5'h0F
`define SO_FIRST_CNT 5'h02

// command codes (control byte bits 7..2)
`define CMD_WR_SERIAL 6'h26
`define CMD_RD_SERIAL 6'h25
`define CMD_WR_PATH 6'h2A
`define CMD_RD_PATH 6'h29
`define CMD_READ_DIAGNOSTICS_CMD 6'h20

// reset values and fixed fields
`define PATH_RESET 8'hFF
`define SERIAL_RESET 8'hFF
`define PAD_BITS 2'h3
`define CODE_OK 2'h3
`define CODES_OK 12'hFFF

`endif

/* File: switch_spi_pkg.sv */
// Purpose: types shared by the six channel switch serial control block
// Assumes: nothing beyond SystemVerilog
// Notes: frame_t follows the serial frame from select to deselect
package switch_spi_pkg;

    // frame progress, reset to prefix whenever select is high
    typedef enum logic [1:0] {
        FR_PREFIX,
        FR_CMD,
        FR_DATA,
        FR_REJECT
    } frame_t;

endpackage

/* File: six_channel_switch_spi_control.sv */
// Purpose: serial slave and output logic of a six channel low side switch
// Assumes: serial clock idles low, select changes with clock low
// Notes: serial side runs on sclk, registers and outputs on mclk
module six_channel_switch_spi_control
    import switch_spi_pkg::*;
#(
    parameter int SYNC_W = 28
) (
    input wire logic mclk, // system clock, 50 MHz
    input wire logic rst_n, // reset pin, active low
    input wire logic cs_n, // chip select, active low
    input wire logic sclk, // serial clock from the master
    input wire logic si, // serial data in
    output logic so_out, // serial data out level
    output logic so_oe, // serial data out drive enable
    input wire logic input_polarity_select, // high: pins high active
    input wire logic [5:0] parallel_input, // pin control, bit 0 = ch 1
    input wire logic [11:0] channel_fault_code, // 2 bits/ch, ch 1 low
    input wire logic [5:0] overtemp_sense, // per channel overtemp
    input wire logic undervoltage, // supply low, active high
    output logic [5:0] power_output, // high: switch on
    output logic fault_flag // any stored fault code, overtemp not included, active high
);
`include "switch_spi_consts.svh"

    // serial side state
    logic frame_clr;
    logic [15:0] rx_reg;
    logic [4:0] cnt_reg;
    frame_t st_reg;
    logic [5:0] cmd_reg;
    logic [15:0] hold_reg;
    logic tag_reg;
    logic so_reg;
    logic so_oe_reg;
    logic [15:0] tx_word;
    logic [7:0] second_byte;

    // system side state
    logic rst_meta;
    logic rst_sync_n;
    logic [SYNC_W-1:0] in_meta;
    logic [SYNC_W-1:0] in_sync;
    logic cs_s;
    logic cs_prev;
    logic tag_s;
    logic uv_s;
    logic pol_s;
    logic [5:0] par_s;
    logic [11:0] code_s;
    logic [5:0] ot_s;
    logic seen_reg;
    logic frame_end;
    logic hit;
    logic diag_clear;
    logic [7:0] channel_path_select_reg;
    logic [7:0] serial_output_control_reg;
    logic [11:0] code_reg;
    logic ot_reg;
    logic any_fault;
    logic [13:0] diag_snap_reg;
    logic [5:0] power_output_reg;
    logic fault_flag_reg;

    // serial logic is held clear while deselected or in reset
    assign frame_clr = cs_n | ~rst_n;

    // receive shift, edge count and prefix check on falling clock
    always_ff @(negedge sclk or posedge frame_clr) begin
        if (frame_clr) begin
            rx_reg <= 16'h0000;
            cnt_reg <= 5'h00;
            st_reg <= FR_PREFIX;
            cmd_reg <= 6'h00;
        end else begin
            rx_reg <= {rx_reg[14:0], si};
            if (cnt_reg != `CNT_MAX) begin
                cnt_reg <= cnt_reg + 5'h01;
            end
            case (st_reg)
                FR_PREFIX: begin
                    if (cnt_reg == 5'h01) begin
                        if ({rx_reg[0], si} == `PREFIX_OK) begin
                            st_reg <= FR_CMD;
                        end else begin
                            st_reg <= FR_REJECT;
                        end
                    end
                end
                FR_CMD: begin
                    if (cnt_reg == `CMD_LAST_CNT) begin
                        cmd_reg <= rx_reg[6:1]; // control bits 7..2
                        st_reg <= FR_DATA;
                    end
                end
                default: begin
                    st_reg <= st_reg;
                end
            endcase
        end
    end

    // completed frame handed over by toggling a tag; a seventeenth
    // edge toggles it back so an overlong frame writes nothing
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            hold_reg <= 16'h0000;
            tag_reg <= 1'b0;
        end else if (!cs_n && st_reg == FR_DATA) begin
            if (cnt_reg == `DATA_LAST_CNT) begin
                hold_reg <= {rx_reg[14:0], si};
                tag_reg <= ~tag_reg;
            end else if (cnt_reg == `FRAME_BITS) begin
                tag_reg <= ~tag_reg;
            end
        end
    end

    // second byte depends on the command seen after eight edges
    always_comb begin
        if (cmd_reg == `CMD_RD_SERIAL) begin
            second_byte = serial_output_control_reg;
        end else if (cmd_reg == `CMD_RD_PATH) begin
            second_byte = channel_path_select_reg;
        end else begin
            second_byte = diag_snap_reg[7:0];
        end
    end

    // first byte: two unused bits, fault, overtemp, channels 6 and 5
    assign tx_word = {2'h0, diag_snap_reg[13:8], second_byte};

    // output bit k leaves on the k-th rising edge, msb first
    always_ff @(posedge sclk or posedge frame_clr) begin
        if (frame_clr) begin
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
        end else begin
            if (cnt_reg < `FRAME_BITS) begin
                so_reg <= tx_word[4'hF - cnt_reg[3:0]];
            end else begin
                so_reg <= 1'b0;
            end
            so_oe_reg <= (st_reg == FR_CMD || st_reg == FR_DATA)
                && cnt_reg >= `SO_FIRST_CNT;
        end
    end

    assign so_out = so_reg;
    assign so_oe = so_oe_reg;

    // reset release through two flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // every foreign level except the held word passes two flops before use
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            in_meta <= {SYNC_W{1'b1}};
            in_sync <= {SYNC_W{1'b1}};
            cs_prev <= 1'b1;
        end else begin
            in_meta <= {cs_n, tag_reg, undervoltage, input_polarity_select,
                parallel_input, channel_fault_code, overtemp_sense};
            in_sync <= in_meta;
            cs_prev <= cs_s;
        end
    end

    assign cs_s = in_sync[27];
    assign tag_s = in_sync[26];
    assign uv_s = in_sync[25];
    assign pol_s = in_sync[24];
    assign par_s = in_sync[23:18];
    assign code_s = in_sync[17:6];
    assign ot_s = in_sync[5:0];

    // a frame counts only if its tag moved: exactly sixteen edges
    // with a matching prefix; select rising is seen late but the
    // held word is quiet by then because the clock has stopped
    assign frame_end = cs_s & ~cs_prev;
    assign hit = frame_end & (tag_s != seen_reg);
    assign diag_clear = hit
        && hold_reg[15:10] == `CMD_READ_DIAGNOSTICS_CMD;

    // register writes at deselect; undervoltage resets like the pin
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            channel_path_select_reg <= `PATH_RESET;
            serial_output_control_reg <= `SERIAL_RESET;
            seen_reg <= 1'b0;
        end else begin
            if (frame_end) begin
                seen_reg <= tag_s;
            end
            if (uv_s) begin
                channel_path_select_reg <= `PATH_RESET;
                serial_output_control_reg <= `SERIAL_RESET;
            end else if (hit) begin
                if (hold_reg[15:10] == `CMD_WR_SERIAL) begin
                    serial_output_control_reg <=
                        {hold_reg[7:2], `PAD_BITS};
                end else if (hold_reg[15:10] == `CMD_WR_PATH) begin
                    channel_path_select_reg <=
                        {hold_reg[7:2], `PAD_BITS};
                end
                // reads and unknown codes leave both alone
            end
        end
    end

    // per channel fault store: a new code wins over a clear
    genvar ch;
    generate
        for (ch = 0; ch < 6; ch++) begin : g_chan
            always_ff @(posedge mclk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    code_reg[2*ch +: 2] <= `CODE_OK;
                end else if (uv_s) begin
                    code_reg[2*ch +: 2] <= `CODE_OK;
                end else if (code_s[2*ch +: 2] != `CODE_OK) begin
                    code_reg[2*ch +: 2] <= code_s[2*ch +: 2];
                end else if (diag_clear) begin
                    code_reg[2*ch +: 2] <= `CODE_OK;
                end
            end

            // drive decision: pin control or low active serial bit
            always_ff @(posedge mclk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    power_output_reg[ch] <= 1'b0;
                end else if (uv_s) begin
                    power_output_reg[ch] <= 1'b0;
                end else if (channel_path_select_reg[ch+2]) begin
                    power_output_reg[ch] <= par_s[ch] == pol_s;
                end else begin
                    power_output_reg[ch] <=
                        ~serial_output_control_reg[ch+2];
                end
            end
        end
    endgenerate

    // overtemp is a latched or of the sensors
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ot_reg <= 1'b0;
        end else if (uv_s) begin
            ot_reg <= 1'b0;
        end else if (|ot_s) begin
            ot_reg <= 1'b1;
        end else if (diag_clear) begin
            ot_reg <= 1'b0;
        end
    end

    assign any_fault = code_reg != `CODES_OK;

    // snapshot frozen while selected so the frame sees one picture
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            diag_snap_reg <= {2'h0, `CODES_OK};
            fault_flag_reg <= 1'b0;
        end else begin
            if (cs_s) begin
                diag_snap_reg <= {any_fault, ot_reg, code_reg};
            end
            fault_flag_reg <= any_fault;
        end
    end

    assign power_output = power_output_reg;
    assign fault_flag = fault_flag_reg;

    // checks on the system clock
    a_serial_write: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        (hit && !uv_s && hold_reg[15:10] == `CMD_WR_SERIAL)
        |=> serial_output_control_reg == {$past(hold_reg[7:2]), 2'h3})
        else $error("serial register not written");

    a_path_write: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        (hit && !uv_s && hold_reg[15:10] == `CMD_WR_PATH)
        |=> channel_path_select_reg == {$past(hold_reg[7:2]), 2'h3})
        else $error("path register not written");

    a_no_bad_write: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        (!hit && !uv_s) |=> $stable(serial_output_control_reg)
        && $stable(channel_path_select_reg))
        else $error("register changed without valid frame");

    a_diag_clear: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        (diag_clear && code_s == 12'hFFF && ot_s == 6'h00)
        |=> code_reg == 12'hFFF && !ot_reg)
        else $error("diagnostics not cleared");

    a_code_sticky: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        (code_reg[1:0] != 2'h3 && !diag_clear && !uv_s)
        |=> code_reg[1:0] != 2'h3)
        else $error("stored fault lost");

    a_serial_drive: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        (!uv_s && !channel_path_select_reg[2])
        |=> power_output[0] == !$past(serial_output_control_reg[2]))
        else $error("serial control drive wrong");

    a_pin_drive: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        (!uv_s && channel_path_select_reg[2])
        |=> power_output[0] == ($past(par_s[0]) == $past(pol_s)))
        else $error("pin control drive wrong");

    a_uv_off: assert property (
        @(posedge mclk) disable iff (!rst_sync_n)
        uv_s |=> power_output == 6'h00
        && serial_output_control_reg == 8'hFF)
        else $error("undervoltage did not reset");

    // checks on the serial clock
    a_reject_quiet: assert property (
        @(posedge sclk) disable iff (frame_clr)
        (st_reg == FR_REJECT || cnt_reg < 5'h02) |=> !so_oe_reg)
        else $error("output driven when not addressed");

    a_msb_order: assert property (
        @(posedge sclk) disable iff (frame_clr)
        (cnt_reg == 5'h02 && st_reg == FR_CMD)
        |=> so_reg == $past(tx_word[13]))
        else $error("wrong first driven bit");

endmodule // six_channel_switch_spi_control

/* File: spi_master_model.sv */
// Purpose: behavioural serial master facing the switch control block
// Assumes: link clock period 160 ns, idles low, stops between frames
// Notes: clock count per frame is free so miscounted frames can be sent
module spi_master_model (
    output logic sclk, // link clock, idles low
    output logic cs_n, // select, active low
    output logic si, // data to the slave
    input wire logic so_out, // data from the slave
    input wire logic so_oe // slave drive enable
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle levels before the first frame
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b1;
    end

    // one frame of n clocks; rx and oe hold what the slave drove per bit
    task automatic xfer(input logic [15:0] tx, input int n,
                        output logic [15:0] rx, output logic [15:0] oe);
        int k;
        rx = '0;
        oe = '0;
        #3; // keeps link edges off the system clock edges
        cs_n = 1'b0; // clock held low across select edges
        #100;
        for (k = 0; k < n; k++) begin
            si = (k < 16) ? tx[15-k] : 1'b0; // msb first
            sclk = 1'b1; // si stable long before the fall
            #70;
            if (k < 16) begin
                rx[15-k] = so_oe ? so_out : ~so_out; // undriven shows inverted
                oe[15-k] = so_oe;
            end
            #10 sclk = 1'b0;
            #80;
        end
        #80 cs_n = 1'b1; // lag over 150 ns, clock low
        si = ~si; // released line must not show a stale value
        #200;
    endtask
endmodule // spi_master_model

/* File: six_channel_switch_spi_control_tb_top.sv */
// Purpose: self checking bench of the switch serial control block
// Assumes: master model drives the link, bench drives the pins
// Notes: expectations are kept in shadow copies of both registers
`include "switch_spi_consts.svh"
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
    err_count++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module six_channel_switch_spi_control_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, rst_n, pol, uv;
    logic [5:0] pin, ot;
    logic [11:0] codes, c;
    wire sclk, cs_n, si, so_out, so_oe, fault;
    wire [5:0] pout;
    int err_count, check_count, seed, i;
    logic [15:0] rx, oe;
    logic [7:0] path, ser, v;
    logic [5:0] bad_pfx [3] = '{6'h3A, 6'h1A, 6'h0A};

    six_channel_switch_spi_control dut (.mclk(mclk), .rst_n(rst_n),
        .cs_n(cs_n), .sclk(sclk), .si(si), .so_out(so_out), .so_oe(so_oe),
        .input_polarity_select(pol), .parallel_input(pin),
        .channel_fault_code(codes), .overtemp_sense(ot),
        .undervoltage(uv), .power_output(pout), .fault_flag(fault));
    spi_master_model m (.sclk(sclk), .cs_n(cs_n), .si(si),
        .so_out(so_out), .so_oe(so_oe));

    // system clock, 20 ns
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // output per channel: path bit picks pin or low active serial bit
    function automatic logic [5:0] exp_out(logic [7:0] p, logic [7:0] s,
                                           logic pl, logic [5:0] pn);
        for (int j = 0; j < 6; j++)
            exp_out[j] = p[j+2] ? (pn[j] == pl) : ~s[j+2];
    endfunction

    task automatic give_verdict();
        if (err_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // low control bits sent as 01 to show they are ignored
    task automatic frame(input logic [5:0] cmd, input logic [7:0] d,
                         input int n);
        m.xfer({cmd, 2'b01, d}, n, rx, oe);
        repeat (10) @(posedge mclk);
    endtask

    task automatic rd(input logic [5:0] cmd);
        frame(cmd, 8'($random(seed)), 16);
        `CHK("so_oe bits", 16'h3FFF, oe)
    endtask

    task automatic chk_regs();
        rd(`CMD_RD_PATH);
        `CHK("path", path, rx[7:0])
        rd(`CMD_RD_SERIAL);
        `CHK("serial", ser, rx[7:0])
        `CHK("idle oe", 1'b0, so_oe)
    endtask

    // hang guard, far beyond the expected run
    initial begin
        #500_000;
        err_count++;
        give_verdict();
    end

    initial begin
        seed = 85747;
        rst_n = 1'b0;
        pol = 1'b0;
        uv = 1'b0;
        pin = 6'h00;
        ot = 6'h00;
        codes = 12'hFFF;
        repeat (8) @(posedge mclk);
        `CHK("rst out", 6'h00, pout)
        `CHK("rst oe", 1'b0, so_oe)
        rst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        path = 8'hFF;
        ser = 8'hFF;
        chk_regs();
        // random writes of both registers with moving pins
        for (i = 0; i < 10; i++) begin
            v = 8'($random(seed));
            if (i[0]) begin
                frame(`CMD_WR_PATH, v, 16);
                path = {v[7:2], 2'b11};
            end else begin
                frame(`CMD_WR_SERIAL, v, 16);
                ser = {v[7:2], 2'b11};
            end
            `CHK("wr resp", {2'b00, 12'hFFF}, rx[13:0])
            pin <= 6'($random(seed));
            pol <= 1'($random(seed));
            repeat (6) @(posedge mclk);
            `CHK("out", exp_out(path, ser, pol, pin), pout)
        end
        chk_regs();
        // miscounted frames must write nothing
        frame(`CMD_WR_PATH, ~path, 15);
        frame(`CMD_WR_SERIAL, ~ser, 17);
        chk_regs();
        // foreign prefixes: tristate throughout, no write
        for (i = 0; i < 3; i++) begin
            frame(bad_pfx[i], ~path, 16);
            `CHK("prefix oe", 16'h0000, oe)
        end
        // unused command: full diagnostics, no write
        frame(6'h2F, ~path, 16);
        `CHK("unused", {2'b00, 12'hFFF}, rx[13:0])
        chk_regs();
        // faults appear, vanish, stay stored until a clean read
        c = {10'($random(seed)), 2'b00};
        codes <= c;
        ot <= 6'h04;
        repeat (8) @(posedge mclk);
        codes <= 12'hFFF;
        ot <= 6'h00;
        repeat (8) @(posedge mclk);
        `CHK("fault pin", 1'b1, fault)
        frame(`CMD_READ_DIAGNOSTICS_CMD, 8'h00, 15);
        rd(`CMD_READ_DIAGNOSTICS_CMD);
        `CHK("diag", {2'b11, c}, rx[13:0])
        rd(`CMD_READ_DIAGNOSTICS_CMD);
        `CHK("cleared", {2'b00, 12'hFFF}, rx[13:0])
        `CHK("fault off", 1'b0, fault)
        // undervoltage behaves as a reset
        frame(`CMD_WR_SERIAL, 8'h00, 16);
        uv <= 1'b1;
        repeat (6) @(posedge mclk);
        `CHK("uv out", 6'h00, pout)
        uv <= 1'b0;
        repeat (6) @(posedge mclk);
        ser = 8'hFF;
        path = 8'hFF;
        chk_regs();
        // second reset in mid-run
        frame(`CMD_WR_PATH, 8'h00, 16);
        frame(`CMD_WR_SERIAL, 8'h00, 16);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        `CHK("rst2 out", 6'h00, pout)
        rst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        chk_regs();
        `CHK("rst2 pin", exp_out(path, ser, pol, pin), pout)
        give_verdict();
    end
endmodule // six_channel_switch_spi_control_tb_top
